// [rtl/hws_cfg.svh]
// Constants for the halt mode wake-up sequencer: offsets, fields, reset values and timings.
`ifndef HWS_CFG_SVH
`define HWS_CFG_SVH

// Register indices; the byte address is four times the index.
`define HWS_IDX_AWU_CSR        8'h2B
`define HWS_IDX_AWU_PR         8'h2C
`define HWS_IDX_MODE_CFG       8'h30
`define HWS_IDX_SEQ_STATUS     8'h31
`define HWS_ADR_AWU_CSR        8'hAC
`define HWS_ADR_AWU_PR         8'hB0
`define HWS_ADR_MODE_CFG       8'hC0
`define HWS_ADR_SEQ_STATUS     8'hC4

// Auto-wake control/status fields.
`define HWS_CSR_ENABLE_BIT     0
`define HWS_CSR_MEASURE_BIT    1
`define HWS_CSR_FLAG_BIT       2

// Mode configuration fields.
`define HWS_CFG_OSC_IE_BIT     0
`define HWS_CFG_LONG_START_BIT 1
`define HWS_CFG_WDG_HALT_BIT   2

// Reset values.
`define HWS_RST_AWU_PR         8'hFF
`define HWS_RST_MODE_CFG       3'h0

// Interrupt mask value that enables all interrupts.
`define HWS_IMASK_OPEN         2'h2

// Fixed divider ahead of the wake prescaler, in wake clock periods.
`define HWS_FIXED_DIV          64
`define HWS_FIXED_DIV_LAST     6'h3F

// Oscillator start-up delays in CPU cycles, and their down-counter loads.
`define HWS_START_SHORT_CYC    256
`define HWS_START_LONG_CYC     4096
`define HWS_START_SHORT_LOAD   13'h00FF
`define HWS_START_LONG_LOAD    13'h0FFF

`endif

// [rtl/hws_pkg.sv]
// Types shared by the halt mode wake-up sequencer.
package hws_pkg;

    typedef enum logic [4:0] {
        HWS_RUN    = 5'h01,
        HWS_HALT   = 5'h02,
        HWS_ACTIVE = 5'h04,
        HWS_AWU    = 5'h08,
        HWS_START  = 5'h10
    } hws_state_type;

endpackage

// [rtl/hws_top.sv]
// Halt mode wake-up sequencer with its classic Wishbone register slave.
//
// Operation
// - Halt picks plain or clock halt by enable.
// - Auto-wake enable selects auto-wake halt unless clock halt is enabled.
// - Entering halt forces interrupt mask open.
// - Pending interrupt at halt wakes at once.
// - Clock halt keeps oscillator and clock counter.
// - Clock halt exits on clock, exit interrupt, reset.
// - Reset exit from clock halt adds start delay.
// - After delay resume by interrupt or vector.
// - Clock halt never causes watchdog reset.
// - Plain and auto-wake halt stop oscillator.
// - Wake clock drives fixed divider and prescaler.
// - Elapsed delay sets flag and raises interrupt.
// - Auto-wake restarts oscillator with stabilise delay.
// - After stabilisation serve the auto-wake interrupt.
// - Reading control/status clears flag and interrupt.
// - Measure bit routes wake clock to capture.
// - Auto-wake halt exits like plain halt.
// - Watchdog option decides reset on halt.
// - Interrupt service saves mask and sets software level.
// - Auto-wake halt lasts sixty-four times prescaler wake periods.
// - Prescaler divides 1..255, zero wakes at once.
`timescale 1ns/1ps
`include "hws_cfg.svh"

module hws_top
    import hws_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        halt_exec_i,
    input  wire logic        irq_pending_i,
    input  wire logic        halt_exit_irq_i,
    input  wire logic        rtc_irq_i,
    input  wire logic        ext_reset_req_i,
    input  wire logic        watchdog_enabled_i,
    input  wire logic        wake_rc_clk_i,
    output logic             cpu_run_o,
    output logic             osc_enable_o,
    output logic             mcc_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             force_imask_o,
    output logic      [1:0]  imask_value_o,
    output logic             awu_irq_o,
    output logic             resume_irq_o,
    output logic             reset_vector_fetch_o,
    output logic             watchdog_reset_o,
    output logic             timer_capture_input_one_o
);

    hws_state_type state_q, state_d;
    logic [5:0]  div_q, div_d;
    logic [7:0]  pre_q, pre_d;
    logic [12:0] start_q, start_d;
    logic        by_reset_q, by_reset_d;
    logic        rc_q;
    logic        auto_wake_enable_q, auto_wake_enable_d;
    logic        auto_wake_measure_q, auto_wake_measure_d;
    logic        auto_wake_flag_q, auto_wake_flag_d;
    logic [7:0]  auto_wake_prescaler_q, auto_wake_prescaler_d;
    logic        osc_int_enable_q, osc_int_enable_d;
    logic        long_start_q, long_start_d;
    logic        watchdog_halt_option_q, watchdog_halt_option_d;
    logic        ack_d;
    logic [31:0] dat_d;
    logic        run_d, osc_d, mcc_d, periph_d, imask_d, resume_d, vector_d, wdg_d, cap_d;
    logic        bus_req, bus_wr, bus_rd, rc_edge, elapse;

    localparam logic [2:0] MODE_RST = `HWS_RST_MODE_CFG;

    function automatic logic [12:0] start_load(input logic long_sel);
        start_load = long_sel ? `HWS_START_LONG_LOAD : `HWS_START_SHORT_LOAD;
    endfunction

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr  = bus_req & we_i & sel_i[0];
    assign bus_rd  = bus_req & ~we_i;
    assign rc_edge = wake_rc_clk_i & ~rc_q;

    // Register file and bus answer.
    always_comb begin
        auto_wake_enable_d     = auto_wake_enable_q;
        auto_wake_measure_d    = auto_wake_measure_q;
        auto_wake_prescaler_d  = auto_wake_prescaler_q;
        osc_int_enable_d       = osc_int_enable_q;
        long_start_d           = long_start_q;
        watchdog_halt_option_d = watchdog_halt_option_q;
        ack_d                  = bus_req;
        dat_d                  = 32'h0000_0000;
        if (bus_wr) begin
            case (adr_i)
                `HWS_ADR_AWU_CSR: begin
                    auto_wake_enable_d  = dat_i[`HWS_CSR_ENABLE_BIT];
                    auto_wake_measure_d = dat_i[`HWS_CSR_MEASURE_BIT];
                end
                `HWS_ADR_AWU_PR: auto_wake_prescaler_d = dat_i[7:0];
                `HWS_ADR_MODE_CFG: begin
                    osc_int_enable_d       = dat_i[`HWS_CFG_OSC_IE_BIT];
                    long_start_d           = dat_i[`HWS_CFG_LONG_START_BIT];
                    watchdog_halt_option_d = dat_i[`HWS_CFG_WDG_HALT_BIT];
                end
                default: ;
            endcase
        end
        if (bus_rd) begin
            case (adr_i)
                `HWS_ADR_AWU_CSR: begin
                    dat_d[`HWS_CSR_ENABLE_BIT]  = auto_wake_enable_q;
                    dat_d[`HWS_CSR_MEASURE_BIT] = auto_wake_measure_q;
                    dat_d[`HWS_CSR_FLAG_BIT]    = auto_wake_flag_q;
                end
                `HWS_ADR_AWU_PR: dat_d[7:0] = auto_wake_prescaler_q;
                `HWS_ADR_MODE_CFG: begin
                    dat_d[`HWS_CFG_OSC_IE_BIT]     = osc_int_enable_q;
                    dat_d[`HWS_CFG_LONG_START_BIT] = long_start_q;
                    dat_d[`HWS_CFG_WDG_HALT_BIT]   = watchdog_halt_option_q;
                end
                `HWS_ADR_SEQ_STATUS: dat_d[4:0] = state_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_wake_enable_q     <= 1'b0;
            auto_wake_measure_q    <= 1'b0;
            auto_wake_prescaler_q  <= `HWS_RST_AWU_PR;
            osc_int_enable_q       <= MODE_RST[`HWS_CFG_OSC_IE_BIT];
            long_start_q           <= MODE_RST[`HWS_CFG_LONG_START_BIT];
            watchdog_halt_option_q <= MODE_RST[`HWS_CFG_WDG_HALT_BIT];
            ack_o                  <= 1'b0;
            dat_o                  <= 32'h0000_0000;
        end else begin
            auto_wake_enable_q     <= auto_wake_enable_d;
            auto_wake_measure_q    <= auto_wake_measure_d;
            auto_wake_prescaler_q  <= auto_wake_prescaler_d;
            osc_int_enable_q       <= osc_int_enable_d;
            long_start_q           <= long_start_d;
            watchdog_halt_option_q <= watchdog_halt_option_d;
            ack_o                  <= ack_d;
            dat_o                  <= dat_d;
        end
    end

    // Halt sequencing, wake divider and start-up delay.
    always_comb begin
        state_d    = state_q;
        div_d      = div_q;
        pre_d      = pre_q;
        start_d    = start_q;
        by_reset_d = by_reset_q;
        imask_d    = 1'b0;
        resume_d   = 1'b0;
        vector_d   = 1'b0;
        wdg_d      = 1'b0;
        elapse     = 1'b0;
        case (state_q)
            HWS_RUN: begin
                if (halt_exec_i) begin
                    if (!osc_int_enable_q && watchdog_enabled_i && watchdog_halt_option_q) begin
                        wdg_d = 1'b1;
                    end else begin
                        imask_d = 1'b1;
                        div_d   = 6'h00;
                        pre_d   = auto_wake_prescaler_q;
                        if (irq_pending_i) begin
                            resume_d = 1'b1;
                        end else if (osc_int_enable_q) begin
                            state_d = HWS_ACTIVE;
                        end else if (auto_wake_enable_q) begin
                            state_d = HWS_AWU;
                        end else begin
                            state_d = HWS_HALT;
                        end
                    end
                end
            end
            HWS_HALT, HWS_AWU: begin
                if (state_q == HWS_AWU) begin
                    if (pre_q == 8'h00) begin
                        elapse = 1'b1;
                    end else if (rc_edge) begin
                        if (div_q == `HWS_FIXED_DIV_LAST) begin
                            div_d = 6'h00;
                            pre_d = pre_q - 8'h01;
                        end else begin
                            div_d = div_q + 6'h01;
                        end
                    end
                end
                if (ext_reset_req_i || halt_exit_irq_i || elapse) begin
                    state_d    = HWS_START;
                    start_d    = start_load(long_start_q);
                    by_reset_d = ext_reset_req_i;
                end
            end
            HWS_ACTIVE: begin
                if (ext_reset_req_i) begin
                    state_d    = HWS_START;
                    start_d    = start_load(long_start_q);
                    by_reset_d = 1'b1;
                end else if (rtc_irq_i || halt_exit_irq_i) begin
                    state_d  = HWS_RUN;
                    resume_d = 1'b1;
                end
            end
            HWS_START: begin
                if (start_q == 13'h0000) begin
                    state_d  = HWS_RUN;
                    resume_d = ~by_reset_q;
                    vector_d = by_reset_q;
                end else begin
                    start_d = start_q - 13'h0001;
                end
            end
            default: state_d = HWS_RUN;
        endcase
        auto_wake_flag_d = (auto_wake_flag_q & ~(bus_rd && adr_i == `HWS_ADR_AWU_CSR)) | elapse;
        run_d    = (state_d == HWS_RUN);
        osc_d    = (state_d != HWS_HALT) && (state_d != HWS_AWU);
        mcc_d    = (state_d == HWS_RUN) || (state_d == HWS_ACTIVE);
        periph_d = (state_d == HWS_RUN);
        cap_d    = auto_wake_measure_q && (state_d == HWS_RUN) && wake_rc_clk_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q                   <= HWS_RUN;
            div_q                     <= 6'h00;
            pre_q                     <= 8'h00;
            start_q                   <= 13'h0000;
            by_reset_q                <= 1'b0;
            rc_q                      <= 1'b0;
            auto_wake_flag_q          <= 1'b0;
            cpu_run_o                 <= 1'b1;
            osc_enable_o              <= 1'b1;
            mcc_clk_en_o              <= 1'b1;
            periph_clk_en_o           <= 1'b1;
            force_imask_o             <= 1'b0;
            imask_value_o             <= `HWS_IMASK_OPEN;
            awu_irq_o                 <= 1'b0;
            resume_irq_o              <= 1'b0;
            reset_vector_fetch_o      <= 1'b0;
            watchdog_reset_o          <= 1'b0;
            timer_capture_input_one_o <= 1'b0;
        end else begin
            state_q                   <= state_d;
            div_q                     <= div_d;
            pre_q                     <= pre_d;
            start_q                   <= start_d;
            by_reset_q                <= by_reset_d;
            rc_q                      <= wake_rc_clk_i;
            auto_wake_flag_q          <= auto_wake_flag_d;
            cpu_run_o                 <= run_d;
            osc_enable_o              <= osc_d;
            mcc_clk_en_o              <= mcc_d;
            periph_clk_en_o           <= periph_d;
            force_imask_o             <= imask_d;
            imask_value_o             <= `HWS_IMASK_OPEN;
            awu_irq_o                 <= auto_wake_flag_d;
            resume_irq_o              <= resume_d;
            reset_vector_fetch_o      <= vector_d;
            watchdog_reset_o          <= wdg_d;
            timer_capture_input_one_o <= cap_d;
        end
    end

endmodule

// [sim/hws_cpu_model.sv]
// Behavioural CPU core with interrupt controller facing the sequencer.
`timescale 1ns/1ps
module hws_cpu_model
    import hws_pkg::*;
#(
    parameter logic [1:0] SW_LEVEL = 2'h1
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       force_imask_i,
    input  wire logic [1:0] imask_value_i,
    input  wire logic       resume_irq_i,
    output logic            halt_exec_o,
    output logic            wake_rc_clk_o,
    output logic [1:0]      imask_o
);
    logic [1:0] div_q;
    logic [1:0] saved_q;
    initial halt_exec_o = 1'b0;
    // Stand-in for the RC oscillator, one rising edge every four cycles.
    always_ff @(posedge clk_i)
        div_q <= rst_i ? 2'h0 : div_q + 2'h1;
    assign wake_rc_clk_o = div_q[1];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            imask_o <= 2'h3;
        end else if (resume_irq_i) begin
            saved_q <= force_imask_i ? imask_value_i : imask_o;
            imask_o <= SW_LEVEL;
        end else if (force_imask_i) begin
            imask_o <= imask_value_i;
        end
    end
    task automatic halt();
        @(posedge clk_i);
        halt_exec_o <= 1'b1;
        @(posedge clk_i);
        halt_exec_o <= 1'b0;
    endtask
endmodule

// [sim/hws_top_chk.sv]
// Concurrent checks on the halt sequencer ports.
`timescale 1ns/1ps
`include "hws_cfg.svh"
module hws_top_chk
    import hws_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       we_i,
    input wire logic [7:0] adr_i,
    input wire logic       ack_o,
    input wire logic       halt_exec_i,
    input wire logic       irq_pending_i,
    input wire logic       cpu_run_o,
    input wire logic       osc_enable_o,
    input wire logic       mcc_clk_en_o,
    input wire logic       periph_clk_en_o,
    input wire logic       force_imask_o,
    input wire logic [1:0] imask_value_o,
    input wire logic       awu_irq_o,
    input wire logic       resume_irq_o,
    input wire logic       reset_vector_fetch_o,
    input wire logic       watchdog_reset_o,
    input wire logic       timer_capture_input_one_o
);
    logic        osc_q;
    logic        osc_d;
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    logic        csr_rd;
    assign csr_rd = cyc_i && stb_i && !we_i && !ack_o && adr_i == `HWS_ADR_AWU_CSR;
    // Counts cycles from oscillator restart until the CPU runs again.
    always_comb begin
        osc_d = rst_i | osc_enable_o;
        cnt_d = cnt_q;
        if (rst_i || cpu_run_o)
            cnt_d = 13'h0000;
        else if (osc_enable_o && !osc_q)
            cnt_d = 13'h0001;
        else if (cnt_q != 13'h0000)
            cnt_d = cnt_q + 13'h0001;
    end
    always_ff @(posedge clk_i) begin
        osc_q <= osc_d;
        cnt_q <= cnt_d;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_HALT_MASK: assert property (cpu_run_o && halt_exec_i |=>
        force_imask_o || watchdog_reset_o) else $error("halt without mask force");
    AST_MASK_VALUE: assert property (force_imask_o |->
        imask_value_o == `HWS_IMASK_OPEN) else $error("forced mask not open");
    AST_PEND_WAKE: assert property (cpu_run_o && halt_exec_i && irq_pending_i |=>
        (resume_irq_o && cpu_run_o) || watchdog_reset_o) else $error("pending irq halted");
    AST_PERIPH_OFF: assert property (!cpu_run_o |-> !periph_clk_en_o)
        else $error("peripherals clocked in halt");
    AST_OSC_OFF: assert property (!osc_enable_o |-> !mcc_clk_en_o && !cpu_run_o)
        else $error("clock running with oscillator off");
    AST_WAKE_FLAG: assert property ($rose(awu_irq_o) |-> osc_enable_o
        && !$past(osc_enable_o) && !cpu_run_o) else $error("flag without restart");
    AST_FLAG_HOLD: assert property (awu_irq_o && !csr_rd |=> awu_irq_o)
        else $error("flag lost without read");
    AST_READ_CLEAR: assert property (csr_rd && cpu_run_o |=> !awu_irq_o)
        else $error("flag kept after read");
    AST_START_LEN: assert property ($rose(cpu_run_o) && cnt_q != 13'h0000 |->
        cnt_q inside {[255:257], [4095:4097]}) else $error("start delay length wrong");
    AST_RESUME_ONE: assert property (resume_irq_o |->
        cpu_run_o && !reset_vector_fetch_o ##1 !resume_irq_o) else $error("resume pulse bad");
    AST_MEASURE: assert property (timer_capture_input_one_o |-> cpu_run_o)
        else $error("capture fed while halted");
    AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not one pulse");
endmodule
bind hws_top hws_top_chk u_chk (.*);

// [sim/tb_halt_mode_wakeup_sequencer.sv]
// Self-checking bench for the halt sequencer.
`timescale 1ns/1ps
`include "hws_cfg.svh"
module tb_halt_mode_wakeup_sequencer
    import hws_pkg::*;
;
    typedef struct {
        logic [5:0] cfg; // osc ie, awu en, wdg option, wdg on, pending, long start
        int         kind; // exit by irq, rtc, reset, auto-wake, none
        logic [3:0] exp; // osc, mcc, watchdog reset, reset vector
        int         cyc;
    } hws_row_type;
    hws_row_type rows[10] = '{'{6'h00, 0, 4'h0, 257}, '{6'h10, 3, 4'h0, 0},
        '{6'h10, 0, 4'h0, 257}, '{6'h20, 1, 4'hC, 1}, '{6'h2C, 0, 4'hC, 1},
        '{6'h30, 1, 4'hC, 1}, '{6'h0C, 4, 4'hE, 0}, '{6'h02, 4, 4'hC, 0},
        '{6'h20, 2, 4'hD, 257}, '{6'h05, 2, 4'h1, 4097}};
    hws_row_type r;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, halt_exec_i, irq_pending_i, ack_o;
    logic        halt_exit_irq_i, rtc_irq_i, ext_reset_req_i, watchdog_enabled_i;
    logic        wake_rc_clk_i, cpu_run_o, osc_enable_o, mcc_clk_en_o, periph_clk_en_o;
    logic        force_imask_o, awu_irq_o, resume_irq_o, reset_vector_fetch_o;
    logic        watchdog_reset_o, timer_capture_input_one_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [1:0]  imask_value_o;
    logic [31:0] dat_i, dat_o, rd;
    logic [7:0]  ra[6] = '{`HWS_ADR_AWU_CSR, `HWS_ADR_AWU_PR, `HWS_ADR_MODE_CFG,
        `HWS_ADR_SEQ_STATUS, 8'h00, 8'hFC};
    logic [31:0] rv[6] = '{32'h0, 32'hFF, 32'h0, 32'h1, 32'h0, 32'h0};
    int          fails = 0, samples_checked = 0, n;
    hws_top DUT (.*);
    hws_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .force_imask_i(force_imask_o),
        .imask_value_i(imask_value_o), .resume_irq_i(resume_irq_o),
        .halt_exec_o(halt_exec_i), .wake_rc_clk_o(wake_rc_clk_i), .imask_o());
    always #5 clk_i = ~clk_i;
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i} <= {2'h3, w, 4'hF};
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        rd = dat_o;
        {cyc_i, stb_i, we_i, sel_i} <= '0;
        if (k >= 50) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic wait_run();
        n = 0;
        do begin
            @(posedge clk_i);
            {halt_exit_irq_i, rtc_irq_i, ext_reset_req_i} <= 3'h0;
            n++;
            #1;
        end while (cpu_run_o !== 1'b1 && n < 6000);
        if (n >= 6000) begin
            fails++;
            finish_test();
        end
    endtask
    initial begin
        {clk_i, cyc_i, stb_i, we_i, irq_pending_i, adr_i, sel_i, dat_i} = '0;
        {halt_exit_irq_i, rtc_irq_i, ext_reset_req_i, watchdog_enabled_i} = '0;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            wb(1'b1, `HWS_ADR_AWU_PR, 8'h01);
            wb(1'b1, `HWS_ADR_MODE_CFG, {5'h0, r.cfg[3], r.cfg[0], r.cfg[5]});
            wb(1'b1, `HWS_ADR_AWU_CSR, {7'h0, r.cfg[4]});
            @(posedge clk_i);
            watchdog_enabled_i <= r.cfg[2];
            irq_pending_i <= r.cfg[1];
            cpu.halt();
            #1;
            chk("run", cpu_run_o, r.kind == 4);
            chk("osc", osc_enable_o, r.exp[3]);
            chk("mcc", mcc_clk_en_o, r.exp[2]);
            chk("periph", periph_clk_en_o, r.kind == 4);
            chk("wdg", watchdog_reset_o, r.exp[1]);
            chk("force", force_imask_o, r.kind != 4 || r.cfg[1]);
            chk("pend", resume_irq_o, r.cfg[1]);
            @(posedge clk_i);
            irq_pending_i <= 1'b0;
            {halt_exit_irq_i, rtc_irq_i, ext_reset_req_i} <= {r.kind == 0, r.kind == 1,
                r.kind == 2};
            if (r.kind != 4) begin
                wait_run();
                if (r.cyc != 0)
                    chk("cycles", n, r.cyc);
                chk("vector", reset_vector_fetch_o, r.exp[0]);
                chk("resume", resume_irq_o, !r.exp[0]);
                if (r.kind == 3) begin
                    chk("awu time", n inside {[504:520]}, 1);
                    chk("awu irq", awu_irq_o, 1);
                    wb(1'b0, `HWS_ADR_AWU_CSR, 8'h00);
                    chk("flag", rd[2], 1);
                    chk("irq clr", awu_irq_o, 0);
                end
            end
            @(posedge clk_i);
            #1;
            if (!r.exp[0] && (r.kind != 4 || r.cfg[1]))
                chk("saved", cpu.saved_q, 2'h2);
            $display("halt row %0d done", i);
        end
        wb(1'b1, `HWS_ADR_AWU_CSR, 8'h02);
        @(posedge clk_i);
        repeat (8) begin
            #1;
            n = wake_rc_clk_i;
            @(posedge clk_i);
            #1;
            chk("capture", timer_capture_input_one_o, n[0]);
        end
        $display("measure done");
        wb(1'b1, `HWS_ADR_AWU_PR, 8'h00);
        wb(1'b1, `HWS_ADR_MODE_CFG, 8'h00);
        wb(1'b1, `HWS_ADR_AWU_CSR, 8'h01);
        cpu.halt();
        wait_run();
        chk("zero pr", n < 300, 1);
        chk("zero irq", awu_irq_o, 1);
        $display("zero prescaler done");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("rst out", {cpu_run_o, osc_enable_o, mcc_clk_en_o, awu_irq_o}, 4'hE);
        wb(1'b1, `HWS_ADR_AWU_CSR, 8'h04);
        wb(1'b1, `HWS_ADR_SEQ_STATUS, 8'hFF);
        wb(1'b1, 8'hFC, 8'h5A);
        foreach (ra[i]) begin
            wb(1'b0, ra[i], 8'h00);
            chk("reg", rd, rv[i]);
        end
        $display("reset and map done");
        finish_test();
    end
endmodule
